// File: src/dit_pkg.sv
package dit_pkg;
  // ---------------------------------------------------------
  // timing
  // ---------------------------------------------------------
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned FILT_UNIT_NS = 500000; // 0.5 ms
  localparam int unsigned TICK_CYC = FILT_UNIT_NS / CLK_NS;

  // ---------------------------------------------------------
  // register offsets (word index on the register port)
  // ---------------------------------------------------------
  localparam logic [8:0] OFS_FSEL0 = 9'h000; // 0x000..0x005
  localparam logic [8:0] OFS_FILT = 9'h006;
  localparam logic [8:0] OFS_CFG = 9'h007;
  localparam logic [8:0] OFS_IN_STAT = 9'h008;
  localparam logic [8:0] OFS_OUT_STAT = 9'h009;
  localparam logic [8:0] OFS_DRV_STAT = 9'h00a;
  localparam logic [8:0] OFS_TABLE = 9'h100; // 0x100..0x1bf
  localparam logic [1:0] FLD_FREQ = 2'h0;
  localparam logic [1:0] FLD_RAMP = 2'h1;
  localparam logic [1:0] FLD_DWELL = 2'h2;

  // ---------------------------------------------------------
  // reset values and config bit positions
  // ---------------------------------------------------------
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [4:0] CFG_RST = 5'h00;
  localparam int unsigned CFG_PID = 0;
  localparam int unsigned CFG_OPTION = 1;
  localparam int unsigned CFG_AUTO = 2;
  localparam int unsigned CFG_STEPPED = 3;
  localparam int unsigned CFG_ANALOG = 4;

  // ---------------------------------------------------------
  // terminal function codes
  // ---------------------------------------------------------
  localparam logic [5:0] F_TRIP_NO = 6'h0d;
  localparam logic [5:0] F_TRIP_NC = 6'h0e;
  localparam logic [5:0] F_ICLR = 6'h0f;
  localparam logic [5:0] F_PID_BYP = 6'h10;
  localparam logic [5:0] F_OPT_BYP = 6'h11;
  localparam logic [5:0] F_REF_FRZ = 6'h12;
  localparam logic [5:0] F_RAMP_FRZ = 6'h13;
  localparam logic [5:0] F_ALT_GAIN = 6'h14;
  localparam logic [5:0] F_SEQ0 = 6'h15;
  localparam logic [5:0] F_SEQ1 = 6'h16;
  localparam logic [5:0] F_SEQ2 = 6'h17;
  localparam logic [5:0] F_MANUAL = 6'h18;
  localparam logic [5:0] F_STEP_ADV = 6'h19;
  localparam logic [5:0] F_LAST_HOLD = 6'h1a;
  localparam logic [5:0] F_TRV_LO = 6'h1b;
  localparam logic [5:0] F_TRV_HI = 6'h1c;
  localparam logic [5:0] F_FLT_RST = 6'h22;
  localparam logic [5:0] F_ESTOP = 6'h23;
  localparam logic [5:0] F_JOG = 6'h24;
  localparam logic [5:0] F_FWD = 6'h25;
  localparam logic [5:0] F_REV = 6'h26;
  localparam logic [5:0] F_SRC_SWAP = 6'h27;

  typedef enum logic [2:0] {
    SQ_IDLE, SQ_RAMP, SQ_DWELL, SQ_WAIT, SQ_HOLD
  } dit_seq_e;
endpackage : dit_pkg

// File: src/dit_input_terminals.sv
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
// Operation
// - closed normally-open trip terminal latches a fault, output off
// - opened normally-closed trip terminal latches a fault, output off
// - integral_clear active forces the PID integral term to zero
// - pid_bypass selects open-loop V/F, taken only while stopped
// - option_bypass_manual hands control to local settings when stopped
// - ref_freeze holds output frequency under analog reference
// - ramp_freeze halts any ramp and holds present frequency
// - alt_proportional_gain selects second P gain during PID
// - sequence_sel pattern picks one of five sequences in auto
// - each sequence has eight steps: frequency, ramp, dwell
// - sequence runs all steps then stops; emergency stop aborts
// - manual select leaves auto sequence, taken only while stopped
// - stepped mode: each step_advance moves to the next step
// - continuous mode: last_step_hold keeps last step frequency
// - traverse offset terminals apply negative or positive offset
// - fault_reset_in clears the latched fault
// - emergency_stop_in commands emergency stop of the output
// - forward_run_in and reverse_run_in issue directional run
// - ref_source_swap takes reference from current input
// - input status: multi inputs bits 0..5, reverse 6, forward 7, inch 8
// - output status: aux outputs bits 0..2, relay bit 3
// - terminal inputs filtered, period is constant times 0.5 ms
// - inch_run_in runs at jog frequency over all other terminals; here jog_run is raised beside run_forward and run_reverse and masks neither
module dit_input_terminals #(
  parameter int unsigned TICK_CYCLES = dit_pkg::TICK_CYC,
  parameter int unsigned FW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [8:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic multi_input_1,
  input wire logic multi_input_2,
  input wire logic multi_input_3,
  input wire logic multi_input_4,
  input wire logic multi_input_5,
  input wire logic multi_input_6,
  input wire logic reverse_run_in,
  input wire logic forward_run_in,
  input wire logic inch_run_in,
  input wire logic aux_output_1,
  input wire logic aux_output_2,
  input wire logic aux_output_3,
  input wire logic relay_contact_out,
  input wire logic drive_stopped,
  output logic fault_latched,
  output logic power_enable,
  output logic integral_clear,
  output logic pid_active,
  output logic option_active,
  output logic auto_active,
  output logic ref_freeze,
  output logic ramp_freeze,
  output logic alt_proportional_gain,
  output logic traverse_offset_low,
  output logic traverse_offset_high,
  output logic emergency_stop,
  output logic run_forward,
  output logic run_reverse,
  output logic jog_run,
  output logic current_ref_sel,
  output logic seq_running,
  output logic [2:0] seq_number,
  output logic [2:0] seq_step,
  output logic [FW-1:0] step_freq,
  output logic [FW-1:0] step_ramp,
  output logic [FW-1:0] step_dwell
);
  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  // any programmable terminal at level 1 holding the code
  function automatic logic func_hit(input logic [35:0] sel,
                                    input logic [5:0] t,
                                    input logic [5:0] code);
    logic h;
    h = 1'b0;
    for (int i = 0; i < 6; i++) begin
      if (t[i] && sel[i*6 +: 6] == code) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction : func_hit

  // select pattern to sequence number, 0 when no valid pattern
  function automatic logic [2:0] seq_decode(input logic [2:0] b);
    logic [2:0] n;
    n = 3'h0;
    case (b)
      3'b001: n = 3'h1;
      3'b010: n = 3'h2;
      3'b100: n = 3'h3;
      3'b011: n = 3'h4;
      3'b101: n = 3'h5;
      default: n = 3'h0;
    endcase
    return n;
  endfunction : seq_decode

  // ---------------------------------------------------------
  // registers and storage
  // ---------------------------------------------------------
  logic [35:0] fsel;
  logic [7:0] filt_const;
  logic [4:0] cfg;
  logic [FW-1:0] freq_mem [64];
  logic [FW-1:0] ramp_mem [64];
  logic [FW-1:0] dwell_mem [64];
  logic [8:0] raw_s1;
  logic [8:0] raw_s2;
  logic [8:0] filt;
  logic [7:0] fcnt [9];
  logic [14:0] div_cnt;
  logic tick;
  logic trip_no_q;
  logic trip_nc_q;
  logic pid_byp_q;
  logic opt_byp_q;
  logic manual_q;
  logic run_d;
  logic adv_d;
  logic [15:0] t_cnt;
  dit_pkg::dit_seq_e seq_st;
  logic [2:0] sel_num;
  logic [5:0] mem_idx;
  logic req_trip_no;
  logic req_trip_nc;
  logic req_adv;
  logic req_hold;
  logic run_cmd;
  logic last_step;

  // ---------------------------------------------------------
  // register port writes
  // ---------------------------------------------------------
  // function selects, filter constant, configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fsel <= '0;
      filt_const <= dit_pkg::FILT_RST;
      cfg <= dit_pkg::CFG_RST;
    end else if (reg_wr) begin
      if (reg_addr <= dit_pkg::OFS_FSEL0 + 9'h005) begin
        fsel[int'(reg_addr[2:0])*6 +: 6] <= reg_wdata[5:0];
      end
      if (reg_addr == dit_pkg::OFS_FILT) begin
        filt_const <= reg_wdata[7:0];
      end
      if (reg_addr == dit_pkg::OFS_CFG) begin
        cfg <= reg_wdata[4:0];
      end
    end
  end

  // step table: address bits 7:6 field, 5:3 sequence, 2:0 step
  always_ff @(posedge clk) begin
    if (reg_wr && reg_addr[8]) begin
      unique case (reg_addr[7:6])
        dit_pkg::FLD_FREQ: freq_mem[reg_addr[5:0]] <= reg_wdata;
        dit_pkg::FLD_RAMP: ramp_mem[reg_addr[5:0]] <= reg_wdata;
        dit_pkg::FLD_DWELL: dwell_mem[reg_addr[5:0]] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------
  // register port reads, data one cycle after the strobe
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= '0;
      if (reg_addr <= dit_pkg::OFS_FSEL0 + 9'h005) begin
        reg_rdata <= {10'h000, fsel[int'(reg_addr[2:0])*6 +: 6]};
      end
      unique case (reg_addr)
        dit_pkg::OFS_FILT: reg_rdata <= {8'h00, filt_const};
        dit_pkg::OFS_CFG: reg_rdata <= {11'h000, cfg};
        dit_pkg::OFS_IN_STAT: reg_rdata <= {7'h00, filt};
        dit_pkg::OFS_OUT_STAT: reg_rdata <= {12'h000, relay_contact_out,
          aux_output_3, aux_output_2, aux_output_1};
        dit_pkg::OFS_DRV_STAT: reg_rdata <= {2'h0, seq_number, seq_step,
          seq_running, auto_active, option_active, pid_active,
          emergency_stop, trip_nc_q, trip_no_q, fault_latched};
        default: ;
      endcase
      if (reg_addr[8]) begin
        unique case (reg_addr[7:6])
          dit_pkg::FLD_FREQ: reg_rdata <= freq_mem[reg_addr[5:0]];
          dit_pkg::FLD_RAMP: reg_rdata <= ramp_mem[reg_addr[5:0]];
          dit_pkg::FLD_DWELL: reg_rdata <= dwell_mem[reg_addr[5:0]];
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  // ---------------------------------------------------------
  // input synchroniser and noise filter
  // ---------------------------------------------------------
  // two flops on every terminal pin
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      raw_s1 <= '0;
      raw_s2 <= '0;
    end else begin
      raw_s1 <= {inch_run_in, forward_run_in, reverse_run_in,
                 multi_input_6, multi_input_5, multi_input_4,
                 multi_input_3, multi_input_2, multi_input_1};
      raw_s2 <= raw_s1;
    end
  end

  // 0.5 ms filter time base
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == 15'(TICK_CYCLES - 1));
      if (div_cnt == 15'(TICK_CYCLES - 1)) begin
        div_cnt <= '0;
      end else begin
        div_cnt <= div_cnt + 15'h0001;
      end
    end
  end

  // new level must hold filt_const ticks; any bounce restarts it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt <= '0;
      for (int i = 0; i < 9; i++) begin
        fcnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (raw_s2[i] == filt[i]) begin
          fcnt[i] <= '0;
        end else if (fcnt[i] >= filt_const) begin
          filt[i] <= raw_s2[i];
          fcnt[i] <= '0;
        end else if (tick) begin
          fcnt[i] <= fcnt[i] + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------
  // function decode
  // ---------------------------------------------------------
  assign req_trip_no = func_hit(fsel, filt[5:0], dit_pkg::F_TRIP_NO);
  assign req_trip_nc = func_hit(fsel, ~filt[5:0], dit_pkg::F_TRIP_NC);
  assign req_adv = func_hit(fsel, filt[5:0], dit_pkg::F_STEP_ADV);
  assign req_hold = func_hit(fsel, filt[5:0], dit_pkg::F_LAST_HOLD);
  assign sel_num = seq_decode({
    func_hit(fsel, filt[5:0], dit_pkg::F_SEQ2),
    func_hit(fsel, filt[5:0], dit_pkg::F_SEQ1),
    func_hit(fsel, filt[5:0], dit_pkg::F_SEQ0)});

  // level commands, registered
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      integral_clear <= 1'b0;
      ref_freeze <= 1'b0;
      ramp_freeze <= 1'b0;
      alt_proportional_gain <= 1'b0;
      traverse_offset_low <= 1'b0;
      traverse_offset_high <= 1'b0;
      emergency_stop <= 1'b0;
      run_forward <= 1'b0;
      run_reverse <= 1'b0;
      jog_run <= 1'b0;
      current_ref_sel <= 1'b0;
    end else begin
      integral_clear <= func_hit(fsel, filt[5:0],
        dit_pkg::F_ICLR);
      ref_freeze <= cfg[dit_pkg::CFG_ANALOG] &&
        func_hit(fsel, filt[5:0], dit_pkg::F_REF_FRZ);
      ramp_freeze <= func_hit(fsel, filt[5:0],
        dit_pkg::F_RAMP_FRZ);
      alt_proportional_gain <= pid_active &&
        func_hit(fsel, filt[5:0], dit_pkg::F_ALT_GAIN);
      traverse_offset_low <= func_hit(fsel, filt[5:0],
        dit_pkg::F_TRV_LO);
      traverse_offset_high <= func_hit(fsel, filt[5:0],
        dit_pkg::F_TRV_HI);
      emergency_stop <= func_hit(fsel, filt[5:0],
        dit_pkg::F_ESTOP);
      run_forward <= filt[7] ||
        func_hit(fsel, filt[5:0], dit_pkg::F_FWD);
      run_reverse <= filt[6] ||
        func_hit(fsel, filt[5:0], dit_pkg::F_REV);
      jog_run <= filt[8] ||
        func_hit(fsel, filt[5:0], dit_pkg::F_JOG);
      current_ref_sel <= func_hit(fsel, filt[5:0],
        dit_pkg::F_SRC_SWAP);
    end
  end

  // ---------------------------------------------------------
  // external trip latch and fault reset
  // ---------------------------------------------------------
  // a set wins over a same-cycle reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trip_no_q <= 1'b0;
      trip_nc_q <= 1'b0;
    end else begin
      if (req_trip_no) begin
        trip_no_q <= 1'b1;
      end else if (func_hit(fsel, filt[5:0], dit_pkg::F_FLT_RST)) begin
        trip_no_q <= 1'b0;
      end
      if (req_trip_nc) begin
        trip_nc_q <= 1'b1;
      end else if (func_hit(fsel, filt[5:0], dit_pkg::F_FLT_RST)) begin
        trip_nc_q <= 1'b0;
      end
    end
  end

  assign fault_latched = trip_no_q | trip_nc_q;
  assign power_enable = !fault_latched && !emergency_stop;

  // ---------------------------------------------------------
  // mode exchanges, taken only while stopped
  // ---------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pid_byp_q <= 1'b0;
      opt_byp_q <= 1'b0;
      manual_q <= 1'b0;
    end else if (drive_stopped) begin
      pid_byp_q <= func_hit(fsel, filt[5:0], dit_pkg::F_PID_BYP);
      opt_byp_q <= func_hit(fsel, filt[5:0], dit_pkg::F_OPT_BYP);
      manual_q <= func_hit(fsel, filt[5:0], dit_pkg::F_MANUAL);
    end
  end

  assign pid_active = cfg[dit_pkg::CFG_PID] && !pid_byp_q;
  assign option_active = cfg[dit_pkg::CFG_OPTION] && !opt_byp_q;
  assign auto_active = cfg[dit_pkg::CFG_AUTO] && !manual_q;

  // ---------------------------------------------------------
  // auto sequence engine
  // ---------------------------------------------------------
  assign run_cmd = run_forward | run_reverse;
  assign mem_idx = {seq_number - 3'h1, seq_step};
  assign last_step = (seq_step == 3'h7);
  assign seq_running = (seq_st != dit_pkg::SQ_IDLE);

  // edge memories for run and step advance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_d <= 1'b0;
      adv_d <= 1'b0;
    end else begin
      run_d <= run_cmd;
      adv_d <= req_adv;
    end
  end

  // ramp then dwell per step, times in 0.5 ms ticks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_st <= dit_pkg::SQ_IDLE;
      seq_number <= 3'h0;
      seq_step <= 3'h0;
      t_cnt <= '0;
      step_freq <= '0;
      step_ramp <= '0;
      step_dwell <= '0;
    end else if (emergency_stop || fault_latched || !auto_active) begin
      seq_st <= dit_pkg::SQ_IDLE;
      seq_step <= 3'h0;
    end else begin
      unique case (seq_st)
        dit_pkg::SQ_IDLE: begin
          if (run_cmd && !run_d && sel_num != 3'h0) begin
            seq_number <= sel_num;
            seq_step <= 3'h0;
            t_cnt <= '0;
            step_freq <= freq_mem[{sel_num - 3'h1, 3'h0}];
            step_ramp <= ramp_mem[{sel_num - 3'h1, 3'h0}];
            step_dwell <= dwell_mem[{sel_num - 3'h1, 3'h0}];
            seq_st <= dit_pkg::SQ_RAMP;
          end
        end
        dit_pkg::SQ_RAMP: begin
          if (t_cnt >= step_ramp) begin
            t_cnt <= '0;
            seq_st <= dit_pkg::SQ_DWELL;
          end else if (tick && !ramp_freeze) begin
            t_cnt <= t_cnt + 16'h0001;
          end
        end
        dit_pkg::SQ_DWELL: begin
          if (t_cnt >= step_dwell) begin
            t_cnt <= '0;
            if (cfg[dit_pkg::CFG_STEPPED]) begin
              seq_st <= last_step ? dit_pkg::SQ_IDLE
                                  : dit_pkg::SQ_WAIT;
            end else if (!last_step) begin
              seq_step <= seq_step + 3'h1;
              seq_st <= dit_pkg::SQ_RAMP;
            end else if (req_hold) begin
              seq_st <= dit_pkg::SQ_HOLD;
            end else begin
              seq_st <= dit_pkg::SQ_IDLE;
            end
          end else if (tick) begin
            t_cnt <= t_cnt + 16'h0001;
          end
        end
        dit_pkg::SQ_WAIT: begin
          if (req_adv && !adv_d) begin
            seq_step <= seq_step + 3'h1;
            seq_st <= dit_pkg::SQ_RAMP;
          end
        end
        dit_pkg::SQ_HOLD: begin
          if (!run_cmd) begin
            seq_st <= dit_pkg::SQ_IDLE;
          end
        end
      endcase
      if (seq_st == dit_pkg::SQ_RAMP && t_cnt == '0) begin
        step_freq <= freq_mem[mem_idx];
        step_ramp <= ramp_mem[mem_idx];
        step_dwell <= dwell_mem[mem_idx];
      end
    end
  end
endmodule : dit_input_terminals

// File: bench/dit_props.sv
`timescale 1ns/100ps
module dit_props (
  input logic clk,
  input logic sys_rst,
  input logic [8:0] reg_addr,
  input logic reg_rd,
  input logic reg_wr,
  input logic [15:0] reg_rdata,
  input logic aux_output_1,
  input logic aux_output_2,
  input logic aux_output_3,
  input logic relay_contact_out,
  input logic drive_stopped,
  input logic fault_latched,
  input logic power_enable,
  input logic emergency_stop,
  input logic pid_active,
  input logic option_active,
  input logic auto_active,
  input logic seq_running,
  input logic [2:0] seq_step
);
  logic [3:0] outs;
  logic [2:0] md;

  // watched words
  assign outs = {relay_contact_out, aux_output_3, aux_output_2,
    aux_output_1};
  assign md = {auto_active, option_active, pid_active};

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_power_cut: assert property (
    power_enable == (!fault_latched && !emergency_stop))
    else $error("power enable wrong");
  a_mode_hold: assert property (
    $changed(md) |-> $past(drive_stopped) || $past(reg_wr))
    else $error("mode changed while running");
  a_out_status: assert property (
    reg_rd && reg_addr == dit_pkg::OFS_OUT_STAT && $stable(outs)
    |=> reg_rdata == {12'h000, $past(outs)})
    else $error("output status wrong");
  a_estop_abort: assert property (
    emergency_stop |-> ##[0:2] !seq_running)
    else $error("sequence not stopped");
  a_step_order: assert property (
    $changed(seq_step) |-> seq_step == $past(seq_step) + 3'h1
    || seq_step == 3'h0)
    else $error("step order wrong");
  a_seq_start: assert property (
    $rose(seq_running) |-> seq_step == 3'h0)
    else $error("sequence start step wrong");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr == 9'h0ff |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  c_seq: cover property ($rose(seq_running));
  c_trip: cover property ($rose(fault_latched));
  c_mode: cover property ($changed(md));
endmodule : dit_props

bind dit_input_terminals dit_props i_props (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .aux_output_1(aux_output_1),
  .aux_output_2(aux_output_2), .aux_output_3(aux_output_3),
  .relay_contact_out(relay_contact_out), .drive_stopped(drive_stopped),
  .fault_latched(fault_latched), .power_enable(power_enable),
  .emergency_stop(emergency_stop), .pid_active(pid_active),
  .option_active(option_active), .auto_active(auto_active),
  .seq_running(seq_running), .seq_step(seq_step));

// File: bench/dit_switches.sv
`timescale 1ns/100ps
module dit_switches (
  input logic clk,
  input logic [8:0] press,
  input logic chatter,
  output logic [8:0] contacts
);
  logic [8:0] held = 9'h000;
  logic [8:0] prev = 9'h000;
  logic [3:0] bounce = 4'h0;

  // contacts settle or bounce
  always_ff @(posedge clk) begin
    if (press != held) begin
      prev <= held;
      held <= press;
      bounce <= chatter ? 4'hb : 4'h0;
    end else if (bounce != 4'h0) begin
      bounce <= bounce - 4'h1;
    end
  end
  assign contacts = bounce[0] ? prev : held; // odd counts show old level
endmodule : dit_switches

// File: bench/dit_input_terminals_test.sv
`timescale 1ns/100ps
module dit_input_terminals_test;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [8:0] reg_addr = 9'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [8:0] press = 9'h000;
  logic chatter = 1'b0;
  logic [3:0] outs = 4'h0;
  logic drive_stopped = 1'b1;
  wire [8:0] pins;
  wire [10:0] lv;
  wire [2:0] md;
  wire fault_latched, power_enable, seq_running;
  wire [2:0] seq_number, seq_step;
  wire [15:0] step_freq, step_ramp, step_dwell;
  int error_cnt = 0;
  int checked = 0;
  int cyc_cnt = 0;
  localparam int W = 10;
  localparam logic [5:0] CODES [11] = '{dit_pkg::F_ICLR,
    dit_pkg::F_REF_FRZ, dit_pkg::F_RAMP_FRZ, dit_pkg::F_ALT_GAIN,
    dit_pkg::F_TRV_LO, dit_pkg::F_TRV_HI, dit_pkg::F_ESTOP,
    dit_pkg::F_FWD, dit_pkg::F_REV, dit_pkg::F_JOG, dit_pkg::F_SRC_SWAP};
  localparam logic [5:0] MC [3] = '{dit_pkg::F_PID_BYP,
    dit_pkg::F_OPT_BYP, dit_pkg::F_MANUAL};
  localparam logic [5:0] SC [6] = '{dit_pkg::F_SEQ0, dit_pkg::F_SEQ1,
    dit_pkg::F_SEQ2, dit_pkg::F_FWD, dit_pkg::F_ESTOP, dit_pkg::F_STEP_ADV};
  localparam logic [2:0] SP [5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h5};
  localparam logic [8:0] TP [5] = '{9'h005, 9'h004, 9'h006, 9'h000,
    9'h006};
  localparam logic [0:4] TF = 5'b11010;

  dit_switches i_sw (.clk(clk), .press(press), .chatter(chatter),
    .contacts(pins));

  dit_input_terminals #(.TICK_CYCLES(4)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .multi_input_1(pins[0]),
    .multi_input_2(pins[1]), .multi_input_3(pins[2]),
    .multi_input_4(pins[3]), .multi_input_5(pins[4]),
    .multi_input_6(pins[5]), .reverse_run_in(pins[6]),
    .forward_run_in(pins[7]), .inch_run_in(pins[8]),
    .aux_output_1(outs[0]), .aux_output_2(outs[1]),
    .aux_output_3(outs[2]), .relay_contact_out(outs[3]),
    .drive_stopped(drive_stopped), .fault_latched(fault_latched),
    .power_enable(power_enable), .integral_clear(lv[0]),
    .pid_active(md[0]), .option_active(md[1]), .auto_active(md[2]),
    .ref_freeze(lv[1]), .ramp_freeze(lv[2]),
    .alt_proportional_gain(lv[3]), .traverse_offset_low(lv[4]),
    .traverse_offset_high(lv[5]), .emergency_stop(lv[6]),
    .run_forward(lv[7]), .run_reverse(lv[8]), .jog_run(lv[9]),
    .current_ref_sel(lv[10]), .seq_running(seq_running),
    .seq_number(seq_number), .seq_step(seq_step),
    .step_freq(step_freq), .step_ramp(step_ramp),
    .step_dwell(step_dwell));

  // -------------------------------------------
  // bus tasks and checking
  // -------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  // clock and hang guard
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // -------------------------------------------
  // test sequence
  // -------------------------------------------
  initial begin
    logic [15:0] d;
    logic [2:0] mx;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(dit_pkg::OFS_IN_STAT, d);
    chk(d, 16'h0000);
    rd(9'h0ff, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      press <= 9'h001 << i;
      outs <= 4'(i);
      cyc(W);
      rd(dit_pkg::OFS_IN_STAT, d);
      chk(d, 16'h0001 << i);
      rd(dit_pkg::OFS_OUT_STAT, d);
      chk(d, 16'(i));
    end
    press <= 9'h000;
    cyc(W);
    wr(dit_pkg::OFS_FILT, 16'h0004);
    press <= 9'h001;
    cyc(8);
    rd(dit_pkg::OFS_IN_STAT, d);
    chk(d, 16'h0000);
    cyc(30);
    rd(dit_pkg::OFS_IN_STAT, d);
    chk(d, 16'h0001);
    chatter <= 1'b1;
    press <= 9'h000;
    cyc(16);
    rd(dit_pkg::OFS_IN_STAT, d);
    chk(d, 16'h0001);
    cyc(30);
    rd(dit_pkg::OFS_IN_STAT, d);
    chk(d, 16'h0000);
    chatter <= 1'b0;
    wr(dit_pkg::OFS_FILT, 16'h0000);
    // latched trips, normally open pin 0, closed pin 2, reset pin 1
    press <= 9'h004;
    cyc(W);
    wr(9'h000, 16'(dit_pkg::F_TRIP_NO));
    wr(9'h001, 16'(dit_pkg::F_FLT_RST));
    wr(9'h002, 16'(dit_pkg::F_TRIP_NC));
    cyc(W);
    chk(16'(fault_latched), 16'h0000);
    for (int i = 0; i < 5; i++) begin
      press <= TP[i];
      cyc(W);
      chk(16'({fault_latched, power_enable}), 16'(2'h1 << TF[i]));
    end
    wr(9'h001, 16'h0000);
    wr(9'h002, 16'h0000);
    press <= 9'h000;
    // mode requests wait for a stop
    wr(dit_pkg::OFS_CFG, 16'h0007);
    for (int k = 0; k < 3; k++) begin
      wr(9'h000, 16'(MC[k]));
      drive_stopped <= 1'b0;
      press <= 9'h001;
      cyc(W);
      chk(16'(md), 16'h0007);
      drive_stopped <= 1'b1;
      cyc(W);
      chk(16'(md), 16'h0007 ^ (16'h0001 << k));
      press <= 9'h000;
      cyc(W);
    end
    // every level function code on pin 0
    wr(dit_pkg::OFS_CFG, 16'h0011);
    for (int i = 0; i < 11; i++) begin
      wr(9'h000, 16'(CODES[i]));
      press <= 9'h001;
      cyc(W);
      chk(16'(lv), 16'h0001 << i);
      press <= 9'h000;
      cyc(W);
      chk(16'(lv), 16'h0000);
    end
    // sequence table
    for (int s = 0; s < 8; s++) begin
      wr(9'h100 + 9'(s), 16'h0100 + 16'(s));
      wr(9'h140 + 9'(s), 16'h0001);
      wr(9'h180 + 9'(s), 16'h0001);
    end
    for (int k = 0; k < 5; k++) begin
      wr(9'h140 + 9'(k * 8), 16'h0010);
    end
    for (int p = 0; p < 6; p++) begin
      wr(9'(p), 16'(SC[p]));
    end
    wr(dit_pkg::OFS_CFG, 16'h0004);
    press <= 9'h009;
    cyc(W);
    chk(16'(seq_number), 16'h0001);
    chk(step_freq, 16'h0100);
    chk({step_ramp[7:0], step_dwell[7:0]}, 16'h1001);
    mx = 3'h0;
    for (int n = 0; n < 900 && seq_running === 1'b1; n++) begin
      if (seq_step > mx) mx = seq_step;
      @(posedge clk);
    end
    chk(16'(mx), 16'h0007);
    chk(16'(seq_running), 16'h0000);
    for (int k = 0; k < 5; k++) begin
      press <= 9'h000;
      cyc(W);
      press <= {6'h01, SP[k]};
      cyc(W);
      chk(16'(seq_number), 16'(k + 1));
      press <= {6'h03, SP[k]};
      cyc(W);
      chk(16'(seq_running), 16'h0000);
    end
    press <= 9'h000;
    wr(dit_pkg::OFS_CFG, 16'h000c);
    cyc(W);
    press <= 9'h009;
    cyc(100);
    chk(16'(seq_step), 16'h0000);
    press <= 9'h029;
    cyc(W);
    chk(16'(seq_step), 16'h0001);
    wrap_up();
  end
endmodule : dit_input_terminals_test
